// ### bcg_commutation.sv
`timescale 1ns/1ps
// Contract
// [R1] Direction 1 Hall table selects high/low pair
// [R2] Direction 0 swaps high and low phases
// [R3] Hall 000/111: fault, all gates off
// [R4] Fast decay off: opposite low-side only
// [R5] Slow decay off: both pair low-sides on
// [R6] Current-limit off applies mode decay pattern
// [R7] Reset: highs off, lows per stored select
// [R8] Dead time between every turn-off and turn-on
// [R9] Bootstrap busy flag blocks high-side turn-on
// [R10] Supply low: fault, coast or brake stored
// [R11] Over-temperature: fault, coast all gates
// [R12] Drain-source high after turn-on latches short
// [R13] Short fault clears on commutation or reset
// [R14] Sense trip starts fixed off-time recirculation
// [R15] Sense ignored for blanking after turn-on
// [R16] Host keeps off-time 10 to 50 us
// [R17] Host may hold PWM or chop it
// [R18] Brake input: all lows on, highs off
// [R19] Reset rise latches brake select
// [R20] Fault output level; only short latched
// [R21] Inputs synchronised; timings are cycle counts
module bcg_commutation
    import bcg_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic hallIn1,
    input wire logic hallIn2,
    input wire logic hallIn3,
    input wire logic dirIn,
    input wire logic pwmIn,
    input wire logic decaySelect,
    input wire logic resetIn,
    input wire logic brakeIn,
    input wire logic brakeOnTriggerSelect,
    input wire logic gateSupplyLow,
    input wire logic overTemp,
    input wire logic senseTrip,
    input wire logic [2:0] bootChargeBusy,
    input wire logic [2:0] drainSourceHigh,
    input wire logic [CW-1:0] deadCycles,
    input wire logic [CW-1:0] blankCycles,
    input wire logic [CW-1:0] offCycles,
    output logic highGateA,
    output logic highGateB,
    output logic highGateC,
    output logic lowGateA,
    output logic lowGateB,
    output logic lowGateC,
    output logic faultOut,
    output logic faultOutEn
);
    typedef struct packed {
        logic resetPrev;
        logic pwmPrev;
        logic brakeStored;
        logic [2:0] hallPrev;
        logic shortFault;
        bcg_cl_e clState;
        logic [CW-1:0] clCnt;
        logic [2:0] highPrev;
        logic [CW-1:0] shortCnt;
        bcg_gate_s gates;
        logic fault;
    } bcg_state_s;

    bcg_state_s st_r;
    bcg_state_s st_nxt;
    bcg_in_s inRaw;
    bcg_in_s inS;
    bcg_gate_s req;
    logic [2:0] deadHigh;
    logic [2:0] deadLow;

    always_comb begin
        inRaw.hall = {hallIn1, hallIn2, hallIn3};
        inRaw.dir = dirIn;
        inRaw.pwm = pwmIn;
        inRaw.decay = decaySelect;
        inRaw.resetIn = resetIn;
        inRaw.brake = brakeIn;
        inRaw.brakeSel = brakeOnTriggerSelect;
        inRaw.supplyLow = gateSupplyLow;
        inRaw.overTemp = overTemp;
        inRaw.senseTrip = senseTrip;
        inRaw.bootBusy = bootChargeBusy;
        inRaw.dsHigh = drainSourceHigh;
    end

    // ------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------
    bcg_sync #(.W(IN_W)) uSync ( // [R21]
        .clk(clk),
        .srst(srst),
        .din(inRaw),
        .dout(inS)
    );

    // ------------------------------------------------------------
    // Commutation, decay and protection
    // ------------------------------------------------------------
    logic hallBad;
    logic commStep;
    logic chopOff;
    bcg_gate_s sel;

    always_comb begin
        st_nxt = st_r;
        sel = bcg_commutate(inS.hall, inS.dir); // [R1] [R2]
        hallBad = (inS.hall == HALL_ALL_ZERO) || (inS.hall == HALL_ALL_ONE); // [R3]
        commStep = inS.hall != st_r.hallPrev;
        st_nxt.hallPrev = inS.hall;
        st_nxt.resetPrev = inS.resetIn;
        st_nxt.pwmPrev = inS.pwm;

        if (inS.resetIn && !st_r.resetPrev) begin
            st_nxt.brakeStored = inS.brakeSel; // [R19]
        end

        // Fixed off-time current limiter with blanking
        unique case (st_r.clState)
            CL_ON: begin
                if (inS.senseTrip) begin // [R14]
                    st_nxt.clState = CL_OFF;
                    st_nxt.clCnt = offCycles;
                end
            end
            CL_OFF: begin
                if (st_r.clCnt != '0) begin
                    st_nxt.clCnt = st_r.clCnt - 1'b1;
                end else begin
                    st_nxt.clState = CL_BLANK; // [R15]
                    st_nxt.clCnt = blankCycles;
                end
            end
            CL_BLANK: begin
                if (st_r.clCnt != '0) begin
                    st_nxt.clCnt = st_r.clCnt - 1'b1;
                end else begin
                    st_nxt.clState = CL_ON;
                end
            end
            default: begin
                st_nxt.clState = CL_BLANK;
                st_nxt.clCnt = blankCycles;
            end
        endcase
        // PWM rising edge or a new step is a fresh turn-on: start blanking unless in CL_OFF
        if ((inS.pwm && !st_r.pwmPrev) || commStep) begin
            if (st_r.clState != CL_OFF) begin
                st_nxt.clState = CL_BLANK; // [R15]
                st_nxt.clCnt = blankCycles;
            end
        end

        chopOff = !inS.pwm || (st_r.clState == CL_OFF); // [R6]

        // Short to ground: drain-source high after blanking of a high side
        if (st_r.gates.high != st_r.highPrev) begin
            st_nxt.shortCnt = blankCycles;
        end else if (st_r.shortCnt != '0) begin
            st_nxt.shortCnt = st_r.shortCnt - 1'b1;
        end
        st_nxt.highPrev = st_r.gates.high;
        if (commStep || (inS.resetIn && !st_r.resetPrev)) begin
            st_nxt.shortFault = 1'b0; // [R13]
        end
        if (st_r.shortCnt == '0 && |(st_r.gates.high & inS.dsHigh)) begin
            st_nxt.shortFault = 1'b1; // [R12]
        end

        req = sel;
        if (chopOff) begin
            req.high = 3'h0;
            if (inS.decay) begin
                req.low = sel.low | sel.high; // [R5]
            end else begin
                req.low = sel.high; // [R4]
            end
        end
        if (st_r.shortFault) begin
            req.high = 3'h0; // [R12]
        end
        req.high = req.high & ~inS.bootBusy; // [R9]
        if (inS.brake) begin
            req = GATES_BRAKE; // [R18]
        end
        if (hallBad) begin
            req = GATES_OFF; // [R3]
        end
        if (inS.resetIn || inS.supplyLow) begin
            req = st_r.brakeStored ? GATES_BRAKE : GATES_OFF; // [R7] [R10] [R19]
        end
        if (inS.overTemp) begin
            req = GATES_OFF; // [R11]
        end
        if (inS.resetIn) begin
            st_nxt.shortFault = 1'b0; // [R13]
        end

        st_nxt.gates = '{high: deadHigh, low: deadLow};
        st_nxt.fault = hallBad || inS.supplyLow || inS.overTemp || st_r.shortFault; // [R20]
    end

    // ------------------------------------------------------------
    // Dead time per half-bridge
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < 3; p++) begin : gDead
            bcg_dead #(.CW(CW)) uDead ( // [R8]
                .clk(clk),
                .srst(srst),
                .reqHigh(req.high[p]),
                .reqLow(req.low[p]),
                .deadCycles(deadCycles),
                .gateHigh(deadHigh[p]),
                .gateLow(deadLow[p])
            );
        end
    endgenerate

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r.resetPrev <= 1'b0;
            st_r.pwmPrev <= 1'b0;
            st_r.brakeStored <= 1'b0;
            st_r.hallPrev <= HALL_ALL_ZERO;
            st_r.shortFault <= 1'b0;
            st_r.clState <= CL_ON;
            st_r.clCnt <= '0;
            st_r.highPrev <= 3'h0;
            st_r.shortCnt <= '0;
            st_r.gates <= GATES_OFF;
            st_r.fault <= 1'b0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign highGateA = st_r.gates.high[0];
    assign highGateB = st_r.gates.high[1];
    assign highGateC = st_r.gates.high[2];
    assign lowGateA = st_r.gates.low[0];
    assign lowGateB = st_r.gates.low[1];
    assign lowGateC = st_r.gates.low[2];
    // Open drain: released (not pulled low) while faulted
    assign faultOut = 1'b0;
    assign faultOutEn = !st_r.fault; // [R20]
endmodule

// ### bcg_pkg.sv
package bcg_pkg;

    // Timing figures as printed and the clock rate
    localparam int CLK_MHZ = 100;
    localparam int DEAD_MIN_NS = 100;
    localparam int DEAD_MIN_CYC = (DEAD_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int OFF_MIN_US = 10;
    localparam int OFF_MIN_CYC = OFF_MIN_US * CLK_MHZ;
    localparam int CNT_W = 16;

    localparam logic [2:0] HALL_ALL_ZERO = 3'h0;
    localparam logic [2:0] HALL_ALL_ONE = 3'h7;
    localparam logic [1:0] SYNC_ZERO = 2'h0;

    // Gate command: high and low sides for phases A..C (bit 0 = A)
    typedef struct packed {
        logic [2:0] high;
        logic [2:0] low;
    } bcg_gate_s;

    localparam bcg_gate_s GATES_OFF = '{high: 3'h0, low: 3'h0};
    localparam bcg_gate_s GATES_BRAKE = '{high: 3'h0, low: 3'h7};

    // Synchronised input bundle
    typedef struct packed {
        logic [2:0] hall;
        logic dir;
        logic pwm;
        logic decay;
        logic resetIn;
        logic brake;
        logic brakeSel;
        logic supplyLow;
        logic overTemp;
        logic senseTrip;
        logic [2:0] bootBusy;
        logic [2:0] dsHigh;
    } bcg_in_s;

    localparam int IN_W = $bits(bcg_in_s);

    typedef enum logic [2:0] {
        CL_ON = 3'b001,
        CL_BLANK = 3'b010,
        CL_OFF = 3'b100
    } bcg_cl_e;

    // Decode of Hall code into selected high/low phase for direction 1
    function automatic bcg_gate_s bcg_commutate(input logic [2:0] h, input logic dir);
        bcg_gate_s g;
        g = GATES_OFF;
        unique case (h)
            3'b101: g = '{high: 3'b001, low: 3'b100};
            3'b100: g = '{high: 3'b010, low: 3'b100};
            3'b110: g = '{high: 3'b010, low: 3'b001};
            3'b010: g = '{high: 3'b100, low: 3'b001};
            3'b011: g = '{high: 3'b100, low: 3'b010};
            3'b001: g = '{high: 3'b001, low: 3'b010};
            default: g = GATES_OFF;
        endcase
        if (!dir) begin
            g = '{high: g.low, low: g.high};
        end
        return g;
    endfunction

endpackage

// ### bcg_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser for a bundle of levels
module bcg_sync
    import bcg_pkg::*;
#(
    parameter int W = IN_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } bcg_sync_s;

    bcg_sync_s st_r;
    bcg_sync_s st_nxt;

    always_comb begin
        st_nxt.meta = din;
        st_nxt.stable = st_r.meta;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign dout = st_r.stable;
endmodule

// ### bcg_dead.sv
`timescale 1ns/1ps
// Dead-time inserter for one half-bridge
module bcg_dead
    import bcg_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic reqHigh,
    input wire logic reqLow,
    input wire logic [CW-1:0] deadCycles,
    output logic gateHigh,
    output logic gateLow
);
    typedef struct packed {
        logic hi;
        logic lo;
        logic [CW-1:0] cnt;
    } bcg_dead_s;

    bcg_dead_s st_r;
    bcg_dead_s st_nxt;

    always_comb begin
        st_nxt = st_r;
        // Any turn-off restarts the gap; turn-on waits until it expires
        if ((st_r.hi && !reqHigh) || (st_r.lo && !reqLow)) begin
            st_nxt.cnt = deadCycles;
        end else if (st_r.cnt != '0) begin
            st_nxt.cnt = st_r.cnt - 1'b1;
        end
        if (!reqHigh) begin
            st_nxt.hi = 1'b0;
        end
        if (!reqLow) begin
            st_nxt.lo = 1'b0;
        end
        if (st_r.cnt == '0 && st_nxt.cnt == '0) begin
            if (reqHigh && !reqLow && !st_r.lo) begin
                st_nxt.hi = 1'b1;
            end
            if (reqLow && !reqHigh && !st_r.hi) begin
                st_nxt.lo = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign gateHigh = st_r.hi;
    assign gateLow = st_r.lo;
endmodule

// ### bcg_commutation_chk.sv
`timescale 1ns/1ps
module bcg_commutation_chk
    import bcg_pkg::*;
#(
    parameter int CW = CNT_W
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic hallIn1,
    input wire logic hallIn2,
    input wire logic hallIn3,
    input wire logic resetIn,
    input wire logic brakeIn,
    input wire logic gateSupplyLow,
    input wire logic overTemp,
    input wire logic [2:0] bootChargeBusy,
    input wire logic [2:0] drainSourceHigh,
    input wire logic [CW-1:0] deadCycles,
    input wire logic highGateA,
    input wire logic highGateB,
    input wire logic highGateC,
    input wire logic lowGateA,
    input wire logic lowGateB,
    input wire logic lowGateC,
    input wire logic faultOut,
    input wire logic faultOutEn
);
    // -------
    // Helpers
    // -------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    wire logic [2:0] hi = {highGateC, highGateB, highGateA};
    wire logic [2:0] lo = {lowGateC, lowGateB, lowGateA};
    wire logic hallBad = (hallIn1 == hallIn2) && (hallIn2 == hallIn3);
    logic [CW-1:0] gapA;
    // Cycles since phase A last switched off
    always_ff @(posedge clk) begin
        if (srst) begin
            gapA <= '1;
        end else if ($fell(highGateA) || $fell(lowGateA)) begin
            gapA <= '0;
        end else if (gapA != '1) begin
            gapA <= gapA + 1'b1;
        end
    end
    // ------
    // Checks
    // ------
    both_sides_a: assert property ((hi & lo) == 3'h0)
        else $error("high and low on together");
    dead_gap_a: assert property (($rose(highGateA) || $rose(lowGateA))
        |-> int'(gapA) + 1 >= int'(deadCycles)) else $error("dead time short");
    boot_hold_a: assert property (bootChargeBusy[0] [*6] |-> !$rose(highGateA))
        else $error("high on while charging");
    short_trip_a: assert property ((highGateA && drainSourceHigh[0]) [*3]
        |-> ##[0:20] (!highGateA && !faultOutEn)) else $error("short not handled");
    hall_coast_a: assert property ((hallBad && !resetIn && !gateSupplyLow) [*6]
        |-> hi == 3'h0 && lo == 3'h0 && !faultOutEn) else $error("bad hall not coasted");
    temp_coast_a: assert property (overTemp [*6]
        |-> hi == 3'h0 && lo == 3'h0 && !faultOutEn) else $error("hot not coasted");
    reset_pattern_a: assert property (resetIn [*8] ##1 resetIn [*4]
        |-> hi == 3'h0 && (lo == 3'h0 || lo == 3'h7)) else $error("reset pattern");
    brake_lows_a: assert property ((brakeIn && !resetIn && !gateSupplyLow && !overTemp
        && !hallBad) [*8] |-> ##[0:8] (hi == 3'h0 && lo == 3'h7)) else $error("no brake");
    fault_pin_a: assert property (faultOut == 1'b0)
        else $error("fault pin driven high");
endmodule

bind bcg_commutation bcg_commutation_chk #(.CW(CW)) CHK (.*);

// ### bcg_bridge_model.sv
`timescale 1ns/1ps
module bcg_bridge_model
    import bcg_pkg::*;
#(
    parameter int TRIP = 12
) (
    input wire logic clk,
    input wire logic srst,
    input wire bcg_gate_s gates,
    input wire logic [2:0] shortGnd,
    input wire logic loaded,
    input wire logic slowBoot,
    output logic [2:0] bootChargeBusy,
    output logic [2:0] drainSourceHigh,
    output logic senseTrip
);
    // ----------------------------
    // Winding current and charging
    // ----------------------------
    logic [7:0] amps;
    logic [2:0] lowWas1 = 3'h0, lowWas2 = 3'h0;
    always_ff @(posedge clk) begin
        lowWas1 <= gates.low;
        lowWas2 <= lowWas1;
        if (srst || !loaded) begin
            amps <= 8'h00;
        end else if (gates.high != 3'h0 && gates.low != 3'h0) begin
            amps <= amps + 8'h01;
        end else if (amps != 8'h00) begin
            amps <= amps - 8'h01;
        end
    end
    // Charge current tails off only after the low side opens
    assign bootChargeBusy = gates.low | lowWas1 | (slowBoot ? lowWas2 : 3'h0);
    // A grounded lead leaves the full supply across a closed high switch
    assign drainSourceHigh = gates.high & shortGnd;
    assign senseTrip = loaded && amps >= 8'(TRIP);
endmodule

// ### test_bcg_commutation.sv
`timescale 1ns/1ps
module test_bcg_commutation
    import bcg_pkg::*;
;
    // ----------------
    // Stimulus and DUT
    // ----------------
    localparam int OFF = OFF_MIN_CYC;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic hallIn1 = 1'b1, hallIn2 = 1'b0, hallIn3 = 1'b1, dirIn = 1'b1, pwmIn = 1'b1;
    logic decaySelect = 1'b0, resetIn = 1'b0, brakeIn = 1'b0, brakeOnTriggerSelect = 1'b0;
    logic gateSupplyLow = 1'b0, overTemp = 1'b0, loaded = 1'b0, slowBoot = 1'b0;
    logic [2:0] shortGnd = 3'h0;
    logic [CNT_W-1:0] deadCycles = 16'h0003, blankCycles = 16'h0004, offCycles = 16'(OFF);
    logic [2:0] bootChargeBusy, drainSourceHigh;
    logic senseTrip, faultOut, faultOutEn;
    logic highGateA, highGateB, highGateC, lowGateA, lowGateB, lowGateC;
    wire logic [2:0] hiG = {highGateC, highGateB, highGateA};
    wire logic [5:0] gNow = {hiG, lowGateC, lowGateB, lowGateA};
    wire bcg_gate_s gates = gNow;
    int err_count = 0, comparisons = 0, cycles = 0, n = 0;
    // Hall, dir, pwm, decay, brake; expected fault enable; expected highs and lows
    logic [15:0] rows [18] = '{16'hb90c, 16'h9914, 16'hd911, 16'h5921, 16'h7922, 16'h390a,
        16'ha921, 16'h8922, 16'hc90a, 16'h490c, 16'h6914, 16'h2911,
        16'hb101, 16'hb505, 16'hbb07, 16'h1800, 16'hf800, 16'hb90c};
    bcg_commutation DUT (.*);
    bcg_bridge_model BRIDGE (.*);
    initial begin
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            report_and_stop();
        end
    end
    // -----
    // Tasks
    // -----
    task automatic chk(input logic [6:0] got, input logic [6:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic go(input logic [5:0] g, input logic f);
        repeat (12) @(negedge clk);
        n = 0;
        while ({gNow, faultOutEn} !== {g, f} && n < 40) begin
            @(negedge clk);
            n++;
        end
        chk({gNow, faultOutEn}, {g, f});
    endtask
    task automatic pulse(input logic sel);
        brakeOnTriggerSelect = sel;
        @(negedge clk);
        resetIn = 1'b1;
        go(sel ? 6'h07 : 6'h00, 1'b1);
        resetIn = 1'b0;
        go(6'h0c, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // --------
    // Sequence
    // --------
    initial begin
        repeat (2) @(negedge clk);
        srst = 1'b0;
        foreach (rows[i]) begin
            {hallIn1, hallIn2, hallIn3, dirIn, pwmIn, decaySelect, brakeIn} = rows[i][15:9];
            go(rows[i][5:0], rows[i][8]);
        end
        pulse(1'b1);
        brakeOnTriggerSelect = 1'b0;
        gateSupplyLow = 1'b1;
        go(6'h07, 1'b0);
        overTemp = 1'b1;
        go(6'h00, 1'b0);
        overTemp = 1'b0;
        gateSupplyLow = 1'b0;
        pulse(1'b0);
        gateSupplyLow = 1'b1;
        go(6'h00, 1'b0);
        gateSupplyLow = 1'b0;
        shortGnd = 3'h1;
        go(6'h04, 1'b0);
        shortGnd = 3'h0;
        go(6'h04, 1'b0);
        hallIn3 = 1'b0;
        go(6'h14, 1'b1);
        shortGnd = 3'h2;
        go(6'h04, 1'b0);
        shortGnd = 3'h0;
        resetIn = 1'b1;
        go(6'h00, 1'b1);
        resetIn = 1'b0;
        go(6'h14, 1'b1);
        hallIn3 = 1'b1;
        for (int m = 0; m < 2; m++) begin
            decaySelect = m[0];
            slowBoot = m[0];
            go(6'h0c, 1'b1);
            loaded = 1'b1;
            n = 0;
            while (hiG[0] !== 1'b0 && n < 200) begin
                @(negedge clk);
                n++;
            end
            repeat (OFF / 2) @(negedge clk);
            chk({gNow, faultOutEn}, {m[0] ? 6'h05 : 6'h01, 1'b1});
            n = OFF / 2;
            while (hiG[0] !== 1'b1 && n < OFF + 400) begin
                @(negedge clk);
                n++;
            end
            chk({6'h00, n >= OFF && n <= OFF + 16}, 7'h01);
            loaded = 1'b0;
        end
        report_and_stop();
    end
endmodule
